// >>> core/sms_slave.sv
// Two-wire serial slave interface: byte and word register access for the LED driver.
// Assumes the host is a conforming bus master whose clock is far slower than i_clk_sys.
//
// Operation
// - The block only ever answers as a slave; it never drives the clock line.
// - Nine byte-wide registers are visible and the two unused string bits of 05h read back their written value.
// - Two registers are read-write (string mask bits and current adjust), seven are read-only.
// - The strap picks address 0101100, 0101110 or 0101111 for ground, open or supply.
// - The first byte holds the address in its upper seven bits and the direction in bit 0.
// - Send Byte, Receive Byte, Read Byte/Word and Write Byte/Word are all served.
// - Every register can be read with a Read Byte or Read Word.
// - Bus writes to read-only registers leave them untouched.
// - Writable registers take Write Byte/Word data; status comes from internal inputs.
// - The strap is captured once after reset before the block joins any transfer.
// - After each Start the next byte is compared with the own address.
// - On a mismatch there is no acknowledge and the bus is ignored until the next Start.
// - The command byte after the address selects the register; drain monitors sit at 00h to 03h.
`timescale 1ns/10ps
`default_nettype none

module sms_slave (
	input  wire logic        i_clk_sys,
	input  wire logic        i_resetn,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic [1:0]  i_strap,
	input  wire logic [31:0] i_vd_mon,
	input  wire logic [7:0]  i_vled_mon,
	input  wire logic [5:0]  i_str12_stat,
	input  wire logic [7:0]  i_str34_stat,
	input  wire logic [7:0]  i_fault_stat,
	output logic             o_sda_out,
	output logic             o_sda_oe_n,
	output logic [1:0]       o_str_unused,
	output logic [7:0]       o_cur_adj,
	output logic [6:0]       o_own_addr,
	output logic             o_addr_ready,
	output logic             o_busy
);

	// ==========================================================
	// Synchronised pins and edge detection.
	logic [3:0] pins_sync;
	logic       scl_s;
	logic       sda_s;
	logic [1:0] strap_s;
	logic       scl_prev_q;
	logic       sda_prev_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;

	sms_sync #(
		.W (4)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_async   ({i_scl, i_sda, i_strap}),
		.o_sync    (pins_sync)
	);

	assign scl_s   = pins_sync[3];
	assign sda_s   = pins_sync[2];
	assign strap_s = pins_sync[1:0];

	// Idle bus is high on both lines, so reset to high to avoid a false Start.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// Edges are found in the same cycle the synchronised level moves, so every
	// reaction of the engine lags the pin by three system clock cycles.
	// The host clock is slow enough that this lag stays well inside the low
	// phase of the bus clock, which is where data may change.
	// Start and Stop both need the clock high on two samples in a row, which
	// keeps a data change that races a clock edge from being taken as either.
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ==========================================================
	// Strap capture, once after reset.
	logic [1:0] strap_cnt_q;

	// The count lets the synchroniser fill with the real strap level first.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			strap_cnt_q  <= 2'h0;
			o_addr_ready <= 1'b0;
			o_own_addr   <= sms_pkg::ADDR_STRAP_GND;
		end else if (!o_addr_ready) begin
			if (strap_cnt_q == sms_pkg::STRAP_WAIT_CYCLES) begin
				o_addr_ready <= 1'b1;
				case (strap_s)
					sms_pkg::STRAP_GND:  o_own_addr <= sms_pkg::ADDR_STRAP_GND;
					sms_pkg::STRAP_OPEN: o_own_addr <= sms_pkg::ADDR_STRAP_OPEN;
					sms_pkg::STRAP_VDD:  o_own_addr <= sms_pkg::ADDR_STRAP_VDD;
					default:             o_own_addr <= sms_pkg::ADDR_STRAP_OPEN;
				endcase
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	// ==========================================================
	// Register read multiplexer.
	logic [7:0] ptr_q;
	logic [7:0] rd_data;

	// Unmapped codes read as zero; the unused bits of 05h read back o_str_unused.
	always_comb begin
		rd_data = 8'h00;
		if (ptr_q <= sms_pkg::REG_VD3) begin
			rd_data = i_vd_mon[ptr_q[1:0]*8 +: 8];
		end else begin
			case (ptr_q)
				sms_pkg::REG_VLED:    rd_data = i_vled_mon;
				sms_pkg::REG_STR12:   rd_data = {o_str_unused, i_str12_stat};
				sms_pkg::REG_STR34:   rd_data = i_str34_stat;
				sms_pkg::REG_FAULT:   rd_data = i_fault_stat;
				sms_pkg::REG_CUR_ADJ: rd_data = o_cur_adj;
				default:              rd_data = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Serial engine.
	sms_pkg::sms_state_t state_q;
	logic [7:0]          shift_q;
	logic [3:0]          bit_cnt_q;
	logic                first_q;
	logic                have_cmd_q;
	logic                rd_dir_q;
	logic                nack_q;
	logic                wr_en;
	logic [7:0]          wr_data;

	// The engine walks through the address byte, then the command byte, then
	// any number of data bytes. The pointer moves on after every data byte in
	// either direction, so a word transfer reaches the command register and the
	// one after it. A repeated Start keeps the pointer, which lets the host set
	// it with a write and then read from it.
	// Limitation: the pointer wraps at eight bits; codes past the map read zero.
	//
	// A byte is complete on the falling clock edge after its eighth bit.
	logic byte_done;
	assign byte_done = scl_fall && (bit_cnt_q == sms_pkg::BITS_PER_BYTE);

	// A received data byte after the command writes the pointed register.
	assign wr_en   = (state_q == sms_pkg::ST_RX) && byte_done && !first_q && have_cmd_q;
	assign wr_data = shift_q;

	// Start and Stop override every state so a broken transfer cannot hang the engine.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			state_q    <= sms_pkg::ST_IDLE;
			shift_q    <= 8'h00;
			bit_cnt_q  <= 4'h0;
			first_q    <= 1'b0;
			have_cmd_q <= 1'b0;
			rd_dir_q   <= 1'b0;
			nack_q     <= 1'b0;
			ptr_q      <= sms_pkg::REG_VD0;
			o_sda_oe_n <= 1'b1;
		end else if (start_det && o_addr_ready) begin
			state_q    <= sms_pkg::ST_RX;
			bit_cnt_q  <= 4'h0;
			first_q    <= 1'b1;
			have_cmd_q <= 1'b0;
			o_sda_oe_n <= 1'b1;
		end else if (stop_det) begin
			state_q    <= sms_pkg::ST_IDLE;
			o_sda_oe_n <= 1'b1;
		end else begin
			case (state_q)
				sms_pkg::ST_IDLE: begin
					o_sda_oe_n <= 1'b1;
				end
				sms_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_q   <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (byte_done) begin
						bit_cnt_q <= 4'h0;
						if (first_q) begin
							first_q <= 1'b0;
							if (shift_q[7:1] == o_own_addr) begin
								rd_dir_q   <= shift_q[0];
								o_sda_oe_n <= 1'b0;
								state_q    <= sms_pkg::ST_ACK;
							end else begin
								state_q <= sms_pkg::ST_IDLE;
							end
						end else if (!have_cmd_q) begin
							ptr_q      <= shift_q;
							have_cmd_q <= 1'b1;
							o_sda_oe_n <= 1'b0;
							state_q    <= sms_pkg::ST_ACK;
						end else begin
							ptr_q      <= ptr_q + 8'h01;
							o_sda_oe_n <= 1'b0;
							state_q    <= sms_pkg::ST_ACK;
						end
					end
				end
				sms_pkg::ST_ACK: begin
					// Release or present the first read bit after the clock falls.
					if (scl_fall) begin
						if (rd_dir_q) begin
							shift_q    <= {rd_data[6:0], 1'b0};
							o_sda_oe_n <= rd_data[7];
							ptr_q      <= ptr_q + 8'h01;
							bit_cnt_q  <= 4'h1;
							state_q    <= sms_pkg::ST_TX;
						end else begin
							o_sda_oe_n <= 1'b1;
							bit_cnt_q  <= 4'h0;
							state_q    <= sms_pkg::ST_RX;
						end
					end
				end
				sms_pkg::ST_TX: begin
					// Only a zero is driven; a one is left to the pull-up.
					if (scl_fall) begin
						if (bit_cnt_q == sms_pkg::BITS_PER_BYTE) begin
							o_sda_oe_n <= 1'b1;
							state_q    <= sms_pkg::ST_RACK;
						end else begin
							o_sda_oe_n <= shift_q[7];
							shift_q    <= {shift_q[6:0], 1'b0};
							bit_cnt_q  <= bit_cnt_q + 4'h1;
						end
					end
				end
				sms_pkg::ST_RACK: begin
					if (scl_rise) begin
						nack_q <= sda_s;
					end else if (scl_fall) begin
						if (nack_q) begin
							state_q <= sms_pkg::ST_IDLE;
						end else begin
							shift_q    <= {rd_data[6:0], 1'b0};
							o_sda_oe_n <= rd_data[7];
							ptr_q      <= ptr_q + 8'h01;
							bit_cnt_q  <= 4'h1;
							state_q    <= sms_pkg::ST_TX;
						end
					end
				end
				default: begin
					state_q    <= sms_pkg::ST_IDLE;
					o_sda_oe_n <= 1'b1;
				end
			endcase
		end
	end

	// ==========================================================
	// Writable registers.

	// Status registers have no write path at all, so bus writes cannot reach them.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_str_unused <= sms_pkg::RST_STR_UNUSED;
			o_cur_adj    <= sms_pkg::RST_CUR_ADJ;
		end else if (wr_en) begin
			case (ptr_q)
				sms_pkg::REG_STR12:   o_str_unused <= wr_data[sms_pkg::STR_UNUSED_LSB +: 2];
				sms_pkg::REG_CUR_ADJ: o_cur_adj    <= wr_data;
				default:              o_str_unused <= o_str_unused;
			endcase
		end
	end

	// ==========================================================
	// Line driver and busy flag.

	// The line is open drain: the driven level is always low. The clock is never driven.
	// Busy is taken from the state one cycle late so that it leaves a flip-flop.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_sda_out <= 1'b0;
			o_busy    <= 1'b0;
		end else begin
			o_sda_out <= 1'b0;
			o_busy    <= (state_q != sms_pkg::ST_IDLE);
		end
	end

endmodule // sms_slave

`default_nettype wire

// >>> core/sms_pkg.sv
// Constants shared by the two-wire slave interface of the LED driver.
// Assumes one system clock at 125 MHz and register indices as byte values.
package sms_pkg;

	// ==========================================================
	// Register map: command code values.
	localparam logic [7:0] REG_VD0     = 8'h00;
	localparam logic [7:0] REG_VD3     = 8'h03;
	localparam logic [7:0] REG_VLED    = 8'h04;
	localparam logic [7:0] REG_STR12   = 8'h05;
	localparam logic [7:0] REG_STR34   = 8'h06;
	localparam logic [7:0] REG_FAULT   = 8'h07;
	localparam logic [7:0] REG_CUR_ADJ = 8'h08;

	// Writable bit positions in the string 1 and 2 register.
	localparam int         STR_UNUSED_LSB = 6;
	localparam logic [7:0] STR12_WR_MASK  = 8'hc0;

	// Values after reset.
	localparam logic [1:0] RST_STR_UNUSED = 2'h0;
	localparam logic [7:0] RST_CUR_ADJ    = 8'h00;

	// ==========================================================
	// Slave addresses chosen by the strap pin.
	localparam logic [6:0] ADDR_STRAP_GND  = 7'h2c;
	localparam logic [6:0] ADDR_STRAP_OPEN = 7'h2e;
	localparam logic [6:0] ADDR_STRAP_VDD  = 7'h2f;

	// Strap sense codes: bit 1 sees above mid-rail, bit 0 sees above low threshold.
	localparam logic [1:0] STRAP_GND  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_VDD  = 2'h3;

	// Cycles the strap must settle through the synchroniser before capture.
	localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

	// Bits in one serial byte.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// Serial engine states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX   = 5'h02,
		ST_ACK  = 5'h04,
		ST_TX   = 5'h08,
		ST_RACK = 5'h10
	} sms_state_t;

endpackage

// >>> core/sms_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels.
// Assumes every bit is an independent slow level; no bus coherency is kept.
`timescale 1ns/10ps
`default_nettype none

module sms_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_resetn,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	logic [W-1:0] meta_q;

	// ==========================================================
	// Only the second stage is visible; the first may be metastable.
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			meta_q <= '0;
			o_sync <= '0;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end

endmodule // sms_sync

`default_nettype wire

// >>> tb/sms_slave_checker.sv
// Port checks for sms_slave.
// Bound onto the slave; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module sms_slave_checker (
	input wire logic       i_clk_sys,
	input wire logic       i_resetn,
	input wire logic       i_scl,
	input wire logic [1:0] i_strap,
	input wire logic       o_sda_out,
	input wire logic       o_sda_oe_n,
	input wire logic [1:0] o_str_unused,
	input wire logic [7:0] o_cur_adj,
	input wire logic [6:0] o_own_addr,
	input wire logic       o_addr_ready,
	input wire logic       o_busy
);
	// ====
	// Checks; all are idle while reset is held.
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	a_pull_only: assert property (!o_sda_oe_n |-> !o_sda_out) else $error("sda high");
	a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl) else $error("sda moved");
	a_low_holds: assert property ($fell(o_sda_oe_n) |=> (!o_sda_oe_n) [*8]) else $error("low short");
	a_addr_map: assert property (o_addr_ready |-> o_own_addr == (&i_strap ? 7'h2f : |i_strap ? 7'h2e : 7'h2c))
		else $error("bad address");
	a_ready_late: assert property (o_addr_ready |-> $past(i_resetn, 4)) else $error("ready early");
	a_addr_fixed: assert property (o_addr_ready |=> $stable(o_own_addr)) else $error("addr moved");
	a_quiet_early: assert property (!o_addr_ready |-> o_sda_oe_n) else $error("early drive");
	a_reg_by_bus: assert property ($changed({o_cur_adj, o_str_unused}) |-> o_busy) else $error("reg moved");
endmodule // sms_slave_checker
bind sms_slave sms_slave_checker i_sms_slave_checker (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
	.i_scl(i_scl), .i_strap(i_strap), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.o_str_unused(o_str_unused), .o_cur_adj(o_cur_adj), .o_own_addr(o_own_addr),
	.o_addr_ready(o_addr_ready), .o_busy(o_busy));
`default_nettype wire

// >>> tb/sms_host.sv
// Behavioural bus master.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module sms_host (
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe_n
);
	localparam realtime Q = 31.25;
	// Both lines idle high; SCL stands still between frames.
	initial begin
		o_scl = 1'b1;
		o_sda_oe_n = 1'b1;
	end
	// Data moves a quarter period after the fall, so it never races SCL.
	task automatic bit_io(input logic b, output logic r);
		#Q o_sda_oe_n = b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q o_scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
	// Serves as a repeated start too.
	task automatic start;
		#Q o_sda_oe_n = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_oe_n = 1'b0;
		#Q o_scl = 1'b0;
	endtask
	task automatic stop;
		#Q o_sda_oe_n = 1'b0;
		#Q o_scl = 1'b1;
		#Q o_sda_oe_n = 1'b1;
		#Q;
	endtask
endmodule // sms_host
`default_nettype wire

// >>> tb/sms_slave_tb.sv
// Bench for sms_slave with a host model.
// Assumes pull-ups on SDA and SCL.
`timescale 1ns/10ps
`default_nettype none
module sms_slave_tb;
	localparam logic [6:0] A = 7'h2c;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic [1:0] strap = 2'h0;
	logic       scl, h_oe_n, oe_n, sdo, rdy, ak, bsy;
	logic [1:0] unu;
	logic [7:0] adj, q;
	logic [6:0] own;
	int         fails = 0;
	int         num_checks = 0;
	wire        sda = h_oe_n & (oe_n | sdo);
	sms_host i_sms_host (.i_sda(sda), .o_scl(scl), .o_sda_oe_n(h_oe_n));
	sms_slave i_sms_slave (.i_clk_sys(clk), .i_resetn(rstn), .i_scl(scl), .i_sda(sda), .i_strap(strap),
		.i_vd_mon(32'h44332211), .i_vled_mon(8'h77), .i_str12_stat(6'h15), .i_str34_stat(8'h5a),
		.i_fault_stat(8'h96), .o_sda_out(sdo), .o_sda_oe_n(oe_n), .o_str_unused(unu),
		.o_cur_adj(adj), .o_own_addr(own), .o_addr_ready(rdy), .o_busy(bsy));
	// 125 MHz system clock.
	always #4 clk = ~clk;
	// ====
	// Shared tasks.
	task automatic check(input logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic summarize;
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rst(input logic [1:0] s, input logic [6:0] a);
		@(negedge clk);
		rstn = 1'b0;
		strap = s;
		repeat (3) @(negedge clk);
		check({bsy, rdy, oe_n, unu, adj}, 13'h0400);
		rstn = 1'b1;
		for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge clk);
		check(own, a);
	endtask
	task automatic tx(input logic [7:0] d, input logic e);
		i_sms_host.byte_io(d, 1'b1, q, ak);
		check(ak, e);
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
		i_sms_host.start();
		tx({A, 1'b0}, 1'b0);
		tx(c, 1'b0);
		for (int i = 0; i < n; i++)
			tx(d[8*i+:8], 1'b0);
		i_sms_host.stop();
	endtask
	// The last byte of a read is refused by the host, which ends it.
	task automatic rd(input logic [7:0] c, input int n, input logic [15:0] e, input logic w);
		if (w) begin
			i_sms_host.start();
			tx({A, 1'b0}, 1'b0);
			tx(c, 1'b0);
		end
		i_sms_host.start();
		tx({A, 1'b1}, 1'b0);
		for (int i = 0; i < n; i++) begin
			i_sms_host.byte_io(8'hff, i == n - 1, q, ak);
			check(q, e[8*i+:8]);
		end
		i_sms_host.stop();
	endtask
	// ====
	// Scenarios.
	task automatic t_write;
		wr(8'h08, 16'h00a5, 1);
		check(adj, 8'ha5);
		wr(8'h05, 16'h3cff, 2);
		check(unu, 2'h3);
		rd(8'h06, 1, 16'h005a, 1);
	endtask
	task automatic t_read;
		rd(8'h00, 2, 16'h2211, 1);
		rd(8'h03, 2, 16'h7744, 1);
		rd(8'h05, 2, 16'h5ad5, 1);
		wr(8'h07, 16'h0000, 0);
		rd(8'h00, 1, 16'h0096, 0);
	endtask
	task automatic t_refuse;
		i_sms_host.start();
		tx(8'h5a, 1'b1);
		tx(8'h08, 1'b1);
		tx(8'h00, 1'b1);
		i_sms_host.stop();
		check(adj, 8'ha5);
		check(bsy, 1'b0);
		wr(8'h08, 16'h003c, 1);
		check(adj, 8'h3c);
		wr(8'h20, 16'h00ff, 1);
		wr(8'h07, 16'h00ff, 1);
		check({unu, adj}, 10'h33c);
		rd(8'h07, 1, 16'h0096, 1);
	endtask
	// Main sequence; the strap is tried in all three positions.
	initial begin
		rst(2'h3, 7'h2f);
		rst(2'h1, 7'h2e);
		rst(2'h0, A);
		t_write();
		t_read();
		t_refuse();
		summarize();
	end
	// Watchdog well beyond the roughly 56 us the transfers take.
	initial begin
		#500us;
		fails++;
		summarize();
	end
endmodule // sms_slave_tb
`default_nettype wire
